// >>> rtl/dcpm_top.sv
// Direct-color pixel port multiplexer with AXI4-Lite control registers
// Summary of operation
// - Two 8-bit control registers select the pixel-port multiplexing mode.
// - Each pixel takes a mode-defined bit count of port data as color.
// - Multiplex ratio is pixels per bus load; one load per strobe pulse in a legal mode.
// - Register 2 bit 7 enables the video pass-through port when set.
// - 24-bit mode: reg1 06/07, reg2 1B ratio 1, 1C ratio 2, 8 overlay.
// - 5-6-5 mode: reg1 05, reg2 02/03/04, ratios 1/2/4, no overlay.
// - 5-5-5 mode: reg1 04, 15 data bits, 1 overlay bit, reg2 02/03/04.
// - 6-6-4 mode: reg1 03, 16 data bits, reg2 02/03/04, ratios 1/2/4.
// - 4-4-4 mode: reg1 01, 12 data, 4 overlay, reg2 12/13/14.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dcpm_top
   import dcpm_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        pixel_load_strobe,
   input  wire logic [63:0] pixel_bus,
   output var  logic [23:0] pix_data,
   output var  logic [7:0]  pix_ovl,
   output var  logic        pix_valid,
   output var  logic        vga_port_en,
   output var  logic        mode_ok
);
   // ==========================================================
   // Mode decode
   logic [7:0]  mux1_r, mux1_nxt, mux2_r, mux2_nxt;
   dcpm_fmt_e   fmt_v;
   logic [2:0]  ratio_v;
   logic [6:0]  busw_v;
   logic [7:0]  bpp_v;
   logic [6:0]  m2;
   logic        mode_ok_v;

   always_comb begin
      fmt_v   = FMT_NONE;
      ratio_v = 3'h0;
      busw_v  = 7'h00;
      bpp_v   = 8'h00;
      m2      = mux2_r[6:0];
      unique case (mux1_r)
         M1_24A, M1_24B: begin
            if (m2 == M2_24_32) begin
               fmt_v = FMT_24; ratio_v = RAT_1; busw_v = BUS_32;
            end else if (m2 == M2_24_64) begin
               fmt_v = FMT_24; ratio_v = RAT_2; busw_v = BUS_64;
            end
         end
         M1_565, M1_555, M1_664, M1_444: begin
            if (m2 == ((mux1_r == M1_444) ? M2_12_16 : M2_16_16)) begin
               ratio_v = RAT_1; busw_v = BUS_16;
            end else if (m2 == ((mux1_r == M1_444) ? M2_12_32 : M2_16_32)) begin
               ratio_v = RAT_2; busw_v = BUS_32;
            end else if (m2 == ((mux1_r == M1_444) ? M2_12_64 : M2_16_64)) begin
               ratio_v = RAT_4; busw_v = BUS_64;
            end
            if (ratio_v != 3'h0) begin
               unique case (mux1_r)
                  M1_565: fmt_v = FMT_565;
                  M1_555: fmt_v = FMT_555;
                  M1_664: fmt_v = FMT_664;
                  default: fmt_v = FMT_444;
               endcase
            end
         end
         default: ;
      endcase
      unique case (fmt_v)
         FMT_24:           bpp_v = BPP_24;
         FMT_565, FMT_664: bpp_v = BPP_16;
         FMT_555:          bpp_v = BPP_15;
         FMT_444:          bpp_v = BPP_12;
         FMT_NONE:         bpp_v = 8'h00;
      endcase
      mode_ok_v = (fmt_v != FMT_NONE);
   end

   // ==========================================================
   // AXI4-Lite slave
   logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, w_strb0_r, w_strb0_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
   logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt, stat_v;
   logic        wr_fire, stat_rd, ovr_r;

   always_comb begin
      stat_v = 32'h0000_0000;
      stat_v[ST_BPP_LSB +: 8]   = bpp_v;
      stat_v[ST_RATIO_LSB +: 3] = ratio_v;
      stat_v[ST_BUSW_LSB +: 7]  = busw_v;
      stat_v[ST_OK_BIT]         = mode_ok_v;
      stat_v[ST_OVR_BIT]        = ovr_r;
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt  = w_full_r;
      w_data_nxt  = w_data_r;
      w_strb0_nxt = w_strb0_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      mux1_nxt    = mux1_r;
      mux2_nxt    = mux2_r;
      stat_rd     = 1'b0;
      wr_fire     = aw_full_r && w_full_r && !bvalid_r;
      if (s_axi_awvalid && awready_r) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_full_nxt  = 1'b1;
         w_data_nxt  = s_axi_wdata[7:0];
         w_strb0_nxt = s_axi_wstrb[0];
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = RESP_OKAY;
         if (aw_addr_r == ADDR_MUX1) begin
            if (w_strb0_r) mux1_nxt = w_data_r;
         end else if (aw_addr_r == ADDR_MUX2) begin
            if (w_strb0_r) mux2_nxt = w_data_r;
         end else if (aw_addr_r != ADDR_STAT) begin
            bresp_nxt = RESP_SLVERR;
         end
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         rdata_nxt  = 32'h0000_0000;
         unique case (s_axi_araddr)
            ADDR_MUX1: rdata_nxt[7:0] = mux1_r;
            ADDR_MUX2: rdata_nxt[7:0] = mux2_r;
            ADDR_STAT: begin
               rdata_nxt = stat_v;
               stat_rd   = 1'b1;
            end
            default: rresp_nxt = RESP_SLVERR;
         endcase
      end
      awready_nxt = !aw_full_nxt && !bvalid_nxt;
      wready_nxt  = !w_full_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_full_r  <= 1'b0;
         w_data_r  <= 8'h00;
         w_strb0_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         arready_r <= 1'b0;
         mux1_r    <= MUX1_RST;
         mux2_r    <= MUX2_RST;
      end else begin
         aw_full_r <= aw_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_full_r  <= w_full_nxt;
         w_data_r  <= w_data_nxt;
         w_strb0_r <= w_strb0_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         arready_r <= arready_nxt;
         mux1_r    <= mux1_nxt;
         mux2_r    <= mux2_nxt;
      end
   end

   // ==========================================================
   // Load strobe and pixel shifter
   logic        q2, q3, lvl_r, lvl_nxt, rise, load_go;
   logic [63:0] pix_in_r, word_r, word_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic [1:0]  idx_r, idx_nxt;
   dcpm_fmt_e   frun_r, frun_nxt;
   dcpm_state_e st_r, st_nxt;
   logic [31:0] s32;
   logic [15:0] s16;
   logic [23:0] data_r, data_nxt;
   logic [7:0]  ovl_r, ovl_nxt;
   logic        valid_r, valid_nxt, ovr_nxt, vga_r, ok_r;

   dcpm_sync3 u_strobe_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (pixel_load_strobe),
      .q2      (q2),
      .q3      (q3)
   );

   always_comb begin
      lvl_nxt   = (q2 == q3) ? q3 : lvl_r;
      rise      = (q2 == q3) && q3 && !lvl_r;
      load_go   = rise && mode_ok_v;
      word_nxt  = word_r;
      cnt_nxt   = cnt_r;
      idx_nxt   = idx_r;
      frun_nxt  = frun_r;
      st_nxt    = st_r;
      data_nxt  = data_r;
      ovl_nxt   = ovl_r;
      valid_nxt = 1'b0;
      ovr_nxt   = stat_rd ? 1'b0 : ovr_r;
      s32 = word_r[{idx_r[0], 5'h00} +: 32];
      s16 = word_r[{idx_r, 4'h0} +: 16];
      if (st_r == SH_RUN) begin
         valid_nxt = 1'b1;
         idx_nxt   = idx_r + 2'h1;
         cnt_nxt   = cnt_r - 3'h1;
         if (cnt_r == 3'h1) st_nxt = SH_IDLE;
         unique case (frun_r)
            FMT_24: begin
               data_nxt = s32[23:0];
               ovl_nxt  = s32[31:24];
            end
            FMT_565, FMT_664: begin
               data_nxt = {8'h00, s16};
               ovl_nxt  = 8'h00;
            end
            FMT_555: begin
               data_nxt = {9'h000, s16[14:0]};
               ovl_nxt  = {7'h00, s16[15]};
            end
            FMT_444: begin
               data_nxt = {12'h000, s16[11:0]};
               ovl_nxt  = {4'h0, s16[15:12]};
            end
            FMT_NONE: begin
               data_nxt = 24'h00_0000;
               ovl_nxt  = 8'h00;
            end
         endcase
      end
      if (load_go) begin
         if (st_r == SH_RUN && cnt_r != 3'h1) ovr_nxt = 1'b1;
         word_nxt = pix_in_r;
         cnt_nxt  = ratio_v;
         idx_nxt  = 2'h0;
         frun_nxt = fmt_v;
         st_nxt   = SH_RUN;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_r    <= 1'b0;
         pix_in_r <= 64'h0000_0000_0000_0000;
         word_r   <= 64'h0000_0000_0000_0000;
         cnt_r    <= 3'h0;
         idx_r    <= 2'h0;
         frun_r   <= FMT_NONE;
         st_r     <= SH_IDLE;
         data_r   <= 24'h00_0000;
         ovl_r    <= 8'h00;
         valid_r  <= 1'b0;
         ovr_r    <= 1'b0;
         vga_r    <= 1'b0;
         ok_r     <= 1'b0;
      end else begin
         lvl_r    <= lvl_nxt;
         pix_in_r <= pixel_bus;
         word_r   <= word_nxt;
         cnt_r    <= cnt_nxt;
         idx_r    <= idx_nxt;
         frun_r   <= frun_nxt;
         st_r     <= st_nxt;
         data_r   <= data_nxt;
         ovl_r    <= ovl_nxt;
         valid_r  <= valid_nxt;
         ovr_r    <= ovr_nxt;
         vga_r    <= mux2_r[VGA_EN_BIT];
         ok_r     <= mode_ok_v;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign pix_data      = data_r;
   assign pix_ovl       = ovl_r;
   assign pix_valid     = valid_r;
   assign vga_port_en   = vga_r;
   assign mode_ok       = ok_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_vga_enable: assert property (wr_fire && aw_addr_r == ADDR_MUX2 && w_strb0_r |-> ##2 vga_r == $past(w_data_r[7], 2)) else $error("pass-through enable wrong");
   a_ratio_load: assert property (load_go |=> cnt_r == $past(ratio_v)) else $error("ratio count wrong");
   a_run_two: assert property (load_go && ratio_v == RAT_2 ##1 !load_go[*2] |-> valid_r ##1 valid_r ##1 !valid_r) else $error("pixel run wrong");
   a_fmt24_pix: assert property (load_go && fmt_v == FMT_24 |-> ##2 data_r == $past(pix_in_r[23:0], 2) && ovl_r == $past(pix_in_r[31:24], 2)) else $error("24-bit pixel wrong");
   a_fmt565_pix: assert property (load_go && fmt_v == FMT_565 |-> ##2 data_r == {8'h00, $past(pix_in_r[15:0], 2)} && ovl_r == 8'h00) else $error("565 pixel wrong");
   a_fmt555_pix: assert property (load_go && fmt_v == FMT_555 |-> ##2 data_r == {9'h000, $past(pix_in_r[14:0], 2)} && ovl_r == {7'h00, $past(pix_in_r[15], 2)}) else $error("555 pixel wrong");
   a_fmt664_map: assert property (mux1_r == M1_664 && mux2_r[6:0] == M2_16_64 |-> fmt_v == FMT_664 && ratio_v == RAT_4 && bpp_v == BPP_16) else $error("664 decode wrong");
   a_fmt444_pix: assert property (load_go && fmt_v == FMT_444 |-> ##2 data_r == {12'h000, $past(pix_in_r[11:0], 2)} && ovl_r == {4'h0, $past(pix_in_r[15:12], 2)}) else $error("444 pixel wrong");
   a_bad_mode: assert property (rise && !mode_ok_v |=> word_r == $past(word_r)) else $error("load taken in bad mode");
   a_bpp_24: assert property (mux1_r == M1_24B && mux2_r[6:0] == M2_24_64 |-> bpp_v == BPP_24 && ratio_v == RAT_2) else $error("24-bit decode wrong");

   c_load_24: cover property (load_go && fmt_v == FMT_24);
   c_load_444_4: cover property (load_go && fmt_v == FMT_444 && ratio_v == RAT_4);
   c_overrun: cover property (load_go && st_r == SH_RUN && cnt_r != 3'h1);
   c_vga_on: cover property ($rose(vga_r) && ok_r);
endmodule
`default_nettype wire

// >>> rtl/dcpm_pkg.sv
// Constants and types for the direct-color pixel port multiplexer
package dcpm_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_MUX1 = 8'h00;
   localparam logic [7:0] ADDR_MUX2 = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] MUX1_RST  = 8'h00;
   localparam logic [7:0] MUX2_RST  = 8'h00;
   localparam int         VGA_EN_BIT = 7;
   // ==========================================================
   // Status field positions
   localparam int ST_BPP_LSB   = 0;
   localparam int ST_RATIO_LSB = 8;
   localparam int ST_BUSW_LSB  = 16;
   localparam int ST_OK_BIT    = 24;
   localparam int ST_OVR_BIT   = 25;
   // ==========================================================
   // Mode codes
   localparam logic [7:0] M1_24A   = 8'h06;
   localparam logic [7:0] M1_24B   = 8'h07;
   localparam logic [7:0] M1_565   = 8'h05;
   localparam logic [7:0] M1_555   = 8'h04;
   localparam logic [7:0] M1_664   = 8'h03;
   localparam logic [7:0] M1_444   = 8'h01;
   localparam logic [6:0] M2_24_32 = 7'h1B;
   localparam logic [6:0] M2_24_64 = 7'h1C;
   localparam logic [6:0] M2_16_16 = 7'h02;
   localparam logic [6:0] M2_16_32 = 7'h03;
   localparam logic [6:0] M2_16_64 = 7'h04;
   localparam logic [6:0] M2_12_16 = 7'h12;
   localparam logic [6:0] M2_12_32 = 7'h13;
   localparam logic [6:0] M2_12_64 = 7'h14;
   // ==========================================================
   // Per-mode figures
   localparam logic [7:0] BPP_24 = 8'h18;
   localparam logic [7:0] BPP_16 = 8'h10;
   localparam logic [7:0] BPP_15 = 8'h0F;
   localparam logic [7:0] BPP_12 = 8'h0C;
   localparam logic [6:0] BUS_16 = 7'h10;
   localparam logic [6:0] BUS_32 = 7'h20;
   localparam logic [6:0] BUS_64 = 7'h40;
   localparam logic [2:0] RAT_1  = 3'h1;
   localparam logic [2:0] RAT_2  = 3'h2;
   localparam logic [2:0] RAT_4  = 3'h4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {FMT_NONE, FMT_24, FMT_565, FMT_555, FMT_664, FMT_444} dcpm_fmt_e;
   typedef enum logic {SH_IDLE, SH_RUN} dcpm_state_e;
endpackage

// >>> rtl/dcpm_sync3.sv
// Three-stage synchroniser for an input from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module dcpm_sync3 (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic d,
   output var  logic q2,
   output var  logic q3
);
   logic q1_r;
   logic q2_r;
   logic q3_r;
   logic q1_nxt;
   logic q2_nxt;
   logic q3_nxt;

   always_comb begin
      q1_nxt = d;
      q2_nxt = q1_r;
      q3_nxt = q2_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q1_r <= 1'b0;
         q2_r <= 1'b0;
         q3_r <= 1'b0;
      end else begin
         q1_r <= q1_nxt;
         q2_r <= q2_nxt;
         q3_r <= q3_nxt;
      end
   end

   assign q2 = q2_r;
   assign q3 = q3_r;
endmodule
`default_nettype wire

// >>> sim/dcpm_fb_model.sv
// Frame buffer model that drives the pixel bus and the load strobe
`timescale 1ns/10ps
`default_nettype none
module dcpm_fb_model (
   input  wire logic        req,
   input  wire logic [63:0] word,
   output var  logic        strobe,
   output var  logic [63:0] bus
);
   // ==========================================
   // Frame generation
   initial begin
      strobe = 1'b0;
      bus    = 64'h0;
   end
   // One load per request at the divided reference period of 200 ns
   // Rate is fixed here and never follows the mode registers
   always @(posedge req) begin
      bus    = word;
      strobe = 1'b1;
      #100 strobe = 1'b0;
      #100 bus = ~word;
   end
endmodule
`default_nettype wire

// >>> sim/dcpm_top_test.sv
// Self-checking testbench for the direct-color pixel port multiplexer
`timescale 1ns/10ps
`default_nettype none
module dcpm_top_test import dcpm_pkg::*;;
   // ==========================================
   // Signals
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        pixel_load_strobe, pix_valid, vga_port_en, mode_ok;
   logic [63:0] pixel_bus;
   logic [63:0] fb_word = 64'h0;
   logic        fb_req = 1'b0;
   logic [23:0] pix_data;
   logic [7:0]  pix_ovl;
   int          errors = 0, compares = 0, cycles = 0;
   logic [31:0] mode_rows [16] = '{
      32'h061B_1801, 32'h061C_1802, 32'h071B_1801, 32'h071C_1802,
      32'h0502_1001, 32'h0503_1002, 32'h0504_1004, 32'h0402_0F01,
      32'h0403_0F02, 32'h0404_0F04, 32'h0302_1001, 32'h0303_1002,
      32'h0304_1004, 32'h0112_0C01, 32'h0113_0C02, 32'h0114_0C04};

   always #12.5 aclk = ~aclk;

   dcpm_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pixel_load_strobe, .pixel_bus, .pix_data, .pix_ovl, .pix_valid,
      .vga_port_en, .mode_ok);

   dcpm_fb_model fb (.req(fb_req), .word(fb_word), .strobe(pixel_load_strobe), .bus(pixel_bus));

   // ==========================================
   // Shared tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         if (!aw_d && s_axi_awready) begin
            aw_d = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_d && s_axi_wready) begin
            w_d = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic load(input logic [63:0] w);
      @(posedge aclk);
      fb_word <= w;
      @(posedge aclk);
      fb_req <= 1'b1;
      @(posedge aclk);
      fb_req <= 1'b0;
   endtask

   // ==========================================
   // Scenarios
   task automatic test_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ADDR_MUX1, d, r);
      chk("mux1 reset", 32'h0, d);
      axi_rd(ADDR_MUX2, d, r);
      chk("mux2 reset", 32'h0, d);
      chk("vga reset", 32'h0, {31'h0, vga_port_en});
      axi_wr(8'h0C, 8'h55, r);
      chk("unmapped bresp", 32'h2, {30'h0, r});
      axi_rd(8'h0C, d, r);
      chk("unmapped rdata", 32'h0, d);
      chk("unmapped rresp", 32'h2, {30'h0, r});
      s_axi_wstrb <= 4'h0;
      axi_wr(ADDR_MUX1, 8'h06, r);
      s_axi_wstrb <= 4'hF;
      axi_rd(ADDR_MUX1, d, r);
      chk("strobe off write", 32'h0, d);
      axi_wr(ADDR_MUX2, 8'h9B, r);
      chk("mux2 bresp", 32'h0, {30'h0, r});
      axi_rd(ADDR_MUX2, d, r);
      chk("mux2 readback", 32'h9B, d);
      chk("vga on", 32'h1, {31'h0, vga_port_en});
      $display("test registers done");
   endtask

   task automatic test_modes();
      logic [31:0] d, row, slot;
      logic [1:0]  r;
      logic [63:0] w;
      logic [23:0] ed;
      logic [7:0]  eo;
      logic [6:0]  bw;
      int          n;
      for (int i = 0; i < 16; i++) begin
         row = mode_rows[i];
         bw = (row[31:25] == 7'h03) ? {row[1:0], 5'h00} : {row[2:0], 4'h0};
         axi_wr(ADDR_MUX1, row[31:24], r);
         axi_wr(ADDR_MUX2, row[23:16] | {i[0], 7'h0}, r);
         axi_rd(ADDR_STAT, d, r);
         chk("stat", {7'h0, 1'b1, 1'b0, bw, 5'h0, row[2:0], row[15:8]}, d);
         chk("stat rresp", 32'h0, {30'h0, r});
         chk("mode ok", 32'h1, {31'h0, mode_ok});
         chk("vga", {31'h0, i[0]}, {31'h0, vga_port_en});
         w = 64'hF1E2_D3C4_B5A6_9788 ^ {8{i[7:0]}};
         load(w);
         n = 0;
         do begin
            @(negedge aclk);
            n++;
         end while (!pix_valid && n < 30);
         for (int p = 0; p < row[2:0]; p++) begin
            slot = (row[31:25] == 7'h03) ? w[32*p +: 32] : {16'h0, w[16*p +: 16]};
            case (row[31:24])
               8'h06, 8'h07: begin
                  ed = slot[23:0];
                  eo = slot[31:24];
               end
               8'h04: begin
                  ed = {9'h0, slot[14:0]};
                  eo = {7'h0, slot[15]};
               end
               8'h01: begin
                  ed = {12'h0, slot[11:0]};
                  eo = {4'h0, slot[15:12]};
               end
               default: begin
                  ed = {8'h0, slot[15:0]};
                  eo = 8'h0;
               end
            endcase
            chk("pixel valid", 32'h1, {31'h0, pix_valid});
            chk("pixel data", {8'h0, ed}, {8'h0, pix_data});
            chk("pixel overlay", {24'h0, eo}, {24'h0, pix_ovl});
            @(negedge aclk);
         end
         chk("run end", 32'h0, {31'h0, pix_valid});
         repeat (8) @(posedge aclk);
      end
      $display("test modes done");
   endtask

   task automatic test_illegal();
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      axi_wr(ADDR_MUX1, 8'h06, r);
      axi_wr(ADDR_MUX2, 8'h02, r);
      axi_rd(ADDR_STAT, d, r);
      chk("illegal legal bit", 32'h0, {31'h0, d[ST_OK_BIT]});
      chk("illegal mode ok", 32'h0, {31'h0, mode_ok});
      load(64'h0123_4567_89AB_CDEF);
      n = 0;
      repeat (20) begin
         @(negedge aclk);
         n += int'(pix_valid === 1'b1);
      end
      chk("illegal pixels", 32'h0, n);
      $display("test illegal done");
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      test_regs();
      test_modes();
      test_illegal();
      end_of_test();
   end
endmodule
`default_nettype wire
